//--- design/smd_core.sv
// Instruction decoder of a small slave controller with program memory, registers and AXI4-Lite.
// Assumes the AXI4-Lite master follows the standard handshake, one access at a time.
`timescale 1ns/1ps
// Function
// RULE1 - Cycle strobe pulses once per instruction machine cycle.
// RULE2 - Reset clears status flags and sets the program counter to zero.
// RULE3 - Expander strobe marks address and data during each expander port access.
// RULE4 - Single-step mode runs one instruction per step request, aligned to strobe.
// RULE5 - Bank select opcodes choose register bank zero or one, one cycle.
// RULE6 - Return with restore pops address and status bits, two cycles.
// RULE7 - Accumulator bit branch jumps when the chosen bit is one.
// RULE8 - Timer flag branch jumps when the flag is set and clears it.
// RULE9 - Input buffer branch jumps when the input buffer full flag is zero.
// RULE10 - Output buffer branch jumps when the output buffer full flag is one.
// RULE11 - Decrement register and branch unless the result is zero.
// RULE12 - Page three table read loads accumulator from page three at accumulator.
// RULE13 - Current page table read loads accumulator from the current page.
// RULE14 - Digit exchange swaps only low nibbles of accumulator and memory.
// RULE15 - Expander opcodes read, write, AND or OR a port, one byte each.
// RULE16 - Immediate move to a register is two bytes, the second the value.
// RULE17 - Reading the host buffer clears the input buffer full flag.
// RULE18 - Writing the host buffer sets the output buffer full flag.
// RULE19 - Two-cycle instructions give two strobe pulses.
module smd_core
  import smd_pkg::*;
#(
  parameter int PM_DEPTH = 1024
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        single_step_in,
  input  wire logic        timer_overflow_in,
  input  wire logic [3:0]  expander_in,
  output logic             cycle_strobe,
  output logic             expander_strobe,
  output logic [3:0]       expander_out,
  output logic             expander_oe,
  output logic             irq
);
  localparam int PMW = $clog2(PM_DEPTH);
  initial begin
    if (PM_DEPTH < 1024 || (PM_DEPTH & (PM_DEPTH - 1)) != 0) begin
      $error("PM_DEPTH must be a power of two of at least 1024.");
    end
  end

  logic [7:0]     pmem [PM_DEPTH];
  logic [7:0]     dmem [16];
  logic [7:0]     stk_lo [8];
  logic [7:0]     stk_hi [8];
  logic [2:0]     sp;
  logic [PMW-1:0] pc;
  logic [7:0]     acc;
  logic [7:0]     opc;
  logic [3:0]     psw_hi;
  logic           bank;
  logic           timer_flag;
  logic           input_buffer_full;
  logic           output_buffer_full;
  logic [7:0]     host_data_buffer;
  logic [7:0]     host_out;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic           run_en;
  logic           step_mode;
  logic           step_pend;
  logic [PMW-1:0] pm_adr;
  logic [2:0]     xphase;
  smd_state_e     state;

  // Bus decode.
  logic aw_go;
  logic ar_go;
  assign aw_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign ar_go = s_axi_arvalid && !s_axi_rvalid;
  wire wr_ctrl  = aw_go && s_axi_awaddr == A_CTRL;
  wire wr_irqs  = aw_go && s_axi_awaddr == A_IRQS;
  wire wr_mask  = aw_go && s_axi_awaddr == A_MASK;
  wire wr_pmadr = aw_go && s_axi_awaddr == A_PMADR;
  wire wr_pmdat = aw_go && s_axi_awaddr == A_PMDAT;
  wire wr_hin   = aw_go && s_axi_awaddr == A_HOSTIN;
  wire rd_hout  = ar_go && s_axi_araddr == A_HOSTOUT;
  wire aw_ok    = wr_ctrl || wr_irqs || wr_mask || wr_pmadr || wr_pmdat || wr_hin;
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == A_CTRL) begin
      rd_val = {29'h0, step_mode ? 1'b0 : 1'b0, step_mode, run_en};
    end else if (s_axi_araddr == A_STAT) begin
      rd_val = {24'h0, psw_hi, bank, timer_flag, output_buffer_full, input_buffer_full};
    end else if (s_axi_araddr == A_IRQS) begin
      rd_val = {29'h0, irq_stat};
    end else if (s_axi_araddr == A_MASK) begin
      rd_val = {29'h0, irq_mask};
    end else if (s_axi_araddr == A_PMADR) begin
      rd_val = 32'(pm_adr);
    end else if (s_axi_araddr == A_HOSTOUT) begin
      rd_val = {24'h0, host_out};
    end else if (s_axi_araddr == A_PC) begin
      rd_val = 32'(pc);
    end else if (s_axi_araddr == A_ACC) begin
      rd_val = {24'h0, acc};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Decode of the current opcode.
  wire [7:0] o = opc;
  wire is_jb   = o[4:0] == OP_JB_LO;
  wire is_dj   = o[7:3] == OP_DJ_HI;
  wire is_xd   = o[7:1] == OP_XD_HI;
  wire is_xin  = o[7:2] == OP_XIN_HI;
  wire is_xout = o[7:2] == OP_XOUT_HI;
  wire is_xand = o[7:2] == OP_XAND_HI;
  wire is_xor  = o[7:2] == OP_XOR_HI;
  wire is_xp   = is_xin || is_xout || is_xand || is_xor;
  wire is_movi = o[7:3] == OP_MOVI_HI;
  wire is_call = o[4:0] == OP_CALL_LO[4:0];
  wire is_return_restore_status = o == OP_RETURN_RESTORE_STATUS;
  wire is_tr   = o == OP_TRD3 || o == OP_TRDC;
  // Branch, call and immediate forms take a second byte; they, table reads, restore-return and expander ops take a second cycle.
  wire two_cyc = is_jb || is_dj || is_movi || is_call || is_return_restore_status || is_tr || is_xp
                 || o == OP_JTF || o == OP_JNIB || o == OP_JOB;
  wire [3:0] rix = {bank, o[2:0]};
  wire [3:0] pix = {bank, 2'b00, o[0]};
  wire [7:0] dj_val = dmem[rix] - 8'h01;
  wire [7:0] xd_ptr = dmem[pix];
  wire [7:0] op2 = pmem[pc];
  wire       take = (is_jb && acc[o[7:5]])                  // RULE7
                 || (o == OP_JTF && timer_flag)              // RULE8
                 || (o == OP_JNIB && !input_buffer_full)     // RULE9
                 || (o == OP_JOB && output_buffer_full)      // RULE10
                 || (is_dj && dj_val != 8'h00);              // RULE11
  wire [PMW-1:0] tr3_adr = PMW'({2'b11, acc});               // RULE12
  wire [PMW-1:0] trc_adr = {pc[PMW-1:8], acc};               // RULE13
  wire [PMW-1:0] br_adr  = {pc[PMW-1:8], op2};
  // The expander combines the digit itself for AND and OR, so only the digit is sent.
  wire [3:0] x_res = acc[3:0];
  // Fetch waits for the expander data phase, so the opcode stays decoded through it.
  wire can_run = run_en && (!step_mode || step_pend) && xphase == 3'h0; // RULE4
  wire halt_ev = step_mode && state == SMD_FETCH && !step_pend && run_en;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OK;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      s_axi_awready <= aw_go;
      s_axi_wready  <= aw_go;
      s_axi_arready <= ar_go;
      if (aw_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (ar_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (wr_pmdat && s_axi_wstrb[0]) begin
      pmem[pm_adr] <= s_axi_wdata[7:0];
    end
  end

  // Interrupt status: a new event wins over a write-one clear in the same cycle.
  wire [IRQ_W-1:0] irq_ev = {halt_ev, rd_hout, 1'b0} | {1'b0, 1'b0,
                            state == SMD_OPER && o == OP_INDBB};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq      <= 1'b0;
      run_en   <= 1'b0;
      step_mode<= 1'b0;
      pm_adr   <= '0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_irqs ? s_axi_wdata[IRQ_W-1:0] : '0)) | irq_ev;
      if (wr_mask) irq_mask <= s_axi_wdata[IRQ_W-1:0];
      irq <= |(irq_stat & irq_mask);
      if (wr_ctrl) begin
        run_en    <= s_axi_wdata[CTRL_RUN];
        step_mode <= s_axi_wdata[CTRL_SS];
      end
      if (wr_pmadr) pm_adr <= s_axi_wdata[PMW-1:0];
      else if (wr_pmdat) pm_adr <= pm_adr + PMW'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= SMD_FETCH;
      pc <= '0;                                                // RULE2
      acc <= 8'h00;
      opc <= OP_NOP;
      psw_hi <= 4'h0;                                          // RULE2
      bank <= 1'b0;                                            // RULE2
      timer_flag <= 1'b0;                                      // RULE2
      input_buffer_full <= 1'b0;                               // RULE2
      output_buffer_full <= 1'b0;                              // RULE2
      host_data_buffer <= 8'h00;
      host_out <= 8'h00;
      sp <= 3'h0;
      step_pend <= 1'b0;
      cycle_strobe <= 1'b0;
      expander_strobe <= 1'b0;
      expander_out <= 4'h0;
      expander_oe <= 1'b0;
      xphase <= 3'h0;
      for (int i = 0; i < 16; i++) dmem[i] <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        stk_lo[i] <= 8'h00;
        stk_hi[i] <= 8'h00;
      end
    end else begin
      cycle_strobe <= 1'b0;
      expander_strobe <= 1'b0;
      if (timer_overflow_in) timer_flag <= 1'b1;
      if (wr_hin) begin
        host_data_buffer <= s_axi_wdata[7:0];
        input_buffer_full <= 1'b1;
      end
      if (rd_hout) output_buffer_full <= 1'b0;
      if (single_step_in || (wr_ctrl && s_axi_wdata[CTRL_STEP])) step_pend <= 1'b1; // RULE4
      case (state)
        SMD_FETCH: begin
          if (can_run) begin
            cycle_strobe <= 1'b1;                              // RULE1
            opc <= pmem[pc];
            pc <= pc + PMW'(1);
            step_pend <= 1'b0;                                 // RULE4
            state <= SMD_OPER;
          end
        end
        SMD_OPER: begin
          state <= SMD_FETCH;
          if (two_cyc && xphase == 3'h0) begin
            cycle_strobe <= 1'b1;                              // RULE19
          end
          if (is_xp) begin
            expander_oe <= 1'b1;                               // RULE3
            expander_strobe <= 1'b1;                           // RULE3
            expander_out <= {o[1:0], is_xin ? 2'b00 : is_xout ? 2'b01 : is_xor ? 2'b10 : 2'b11};
            xphase <= 3'h1;
          end
          if (o == OP_BANK0) bank <= 1'b0;                     // RULE5
          if (o == OP_BANK1) bank <= 1'b1;                     // RULE5
          if (o == OP_JTF) timer_flag <= timer_overflow_in;    // RULE8
          if (is_dj) dmem[rix] <= dj_val;                      // RULE11
          if (is_movi) dmem[rix] <= op2;                       // RULE16
          if (is_movi || (!take && (is_jb || is_dj || o == OP_JTF || o == OP_JNIB
              || o == OP_JOB))) pc <= pc + PMW'(1);
          if (take) pc <= br_adr;
          if (o == OP_TRD3) acc <= pmem[tr3_adr];              // RULE12
          if (o == OP_TRDC) acc <= pmem[trc_adr];              // RULE13
          if (is_xd) begin
            acc <= {acc[7:4], dmem[xd_ptr[3:0]][3:0]};         // RULE14
            dmem[xd_ptr[3:0]] <= {dmem[xd_ptr[3:0]][7:4], acc[3:0]};
          end
          if (o == OP_INDBB) begin
            acc <= host_data_buffer;
            if (!wr_hin) input_buffer_full <= 1'b0;            // RULE17
          end
          if (o == OP_OUTDBB) begin
            host_out <= acc;
            output_buffer_full <= 1'b1;                        // RULE18
          end
          if (is_call) begin
            stk_lo[sp] <= 8'(pc + PMW'(1));
            stk_hi[sp] <= {bank, psw_hi[2:0], 4'(PMW'(pc + PMW'(1)) >> 8)};
            sp <= sp + 3'h1;
            pc <= PMW'({o[7:5], op2});
          end
          if (is_return_restore_status) begin
            pc <= PMW'({stk_hi[sp - 3'h1][3:0], stk_lo[sp - 3'h1]});  // RULE6
            bank <= stk_hi[sp - 3'h1][7];                      // RULE6
            psw_hi[2:0] <= stk_hi[sp - 3'h1][6:4];             // RULE6
            sp <= sp - 3'h1;
          end
        end
        default: state <= SMD_FETCH;
      endcase
      if (xphase == 3'h1) begin
        expander_strobe <= 1'b1;                               // RULE3
        if (is_xin) expander_oe <= 1'b0;
        else expander_out <= x_res;                            // RULE15
        xphase <= 3'h2;
      end else if (xphase == 3'h2) begin
        if (is_xin) acc <= {4'h0, expander_in};                // RULE15
        expander_oe <= 1'b0;
        xphase <= 3'h0;
      end
    end
  end

  AST_STROBE_PULSE: assert property (@(posedge clk) disable iff (!resetn)
    cycle_strobe && state == SMD_FETCH |=> !cycle_strobe || state == SMD_OPER) // RULE1
    else $error("Cycle strobe held too long.");
  AST_RESET_PC: assert property (@(posedge clk) $rose(resetn) |-> pc == '0) // RULE2
    else $error("Program counter not zero after reset.");
  AST_EXP_STROBE: assert property (@(posedge clk) disable iff (!resetn)
    $rose(expander_strobe) |-> expander_oe) // RULE3
    else $error("Expander strobe without port access.");
  AST_STEP_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    state == SMD_FETCH && step_mode && !step_pend |=> state == SMD_FETCH) // RULE4
    else $error("Single step advanced without request.");
  AST_BANK1: assert property (@(posedge clk) disable iff (!resetn)
    state == SMD_OPER && opc == OP_BANK1 |=> bank) // RULE5
    else $error("Bank one not selected.");
  AST_TIMER_CLR: assert property (@(posedge clk) disable iff (!resetn)
    state == SMD_OPER && opc == OP_JTF && !timer_overflow_in |=> !timer_flag) // RULE8
    else $error("Timer flag not cleared by branch.");
  AST_IBF_CLR: assert property (@(posedge clk) disable iff (!resetn)
    state == SMD_OPER && opc == OP_INDBB && !wr_hin |=> !input_buffer_full) // RULE17
    else $error("Input buffer flag not cleared.");
  AST_OBF_SET: assert property (@(posedge clk) disable iff (!resetn)
    state == SMD_OPER && opc == OP_OUTDBB |=> output_buffer_full && host_out == $past(acc)) // RULE18
    else $error("Output buffer flag not set.");
  AST_TWO_STROBE: assert property (@(posedge clk) disable iff (!resetn)
    state == SMD_OPER && opc == OP_JOB |=> cycle_strobe) // RULE19
    else $error("Second strobe missing.");
endmodule // smd_core

//--- design/smd_pkg.sv
// Package for the slave controller instruction decoder: opcodes, register map, timing.
// Assumes a 50 MHz clock and an AXI4-Lite master with 32-bit data.
package smd_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam logic [7:0] OP_NOP        = 8'h00;
  localparam logic [7:0] OP_BANK0      = 8'hC5;
  localparam logic [7:0] OP_BANK1      = 8'hD5;
  localparam logic [7:0] OP_RETURN_RESTORE_STATUS       = 8'h93;
  localparam logic [7:0] OP_JTF        = 8'h16;
  localparam logic [7:0] OP_JNIB       = 8'hD6;
  localparam logic [7:0] OP_JOB        = 8'h86;
  localparam logic [4:0] OP_JB_LO      = 5'h12;
  localparam logic [4:0] OP_DJ_HI      = 5'h1D;
  localparam logic [7:0] OP_TRD3       = 8'hE3;
  localparam logic [7:0] OP_TRDC       = 8'hA3;
  localparam logic [6:0] OP_XD_HI      = 7'h18;
  localparam logic [5:0] OP_XIN_HI     = 6'h03;
  localparam logic [5:0] OP_XOUT_HI    = 6'h0F;
  localparam logic [5:0] OP_XAND_HI    = 6'h27;
  localparam logic [5:0] OP_XOR_HI     = 6'h23;
  localparam logic [4:0] OP_MOVI_HI    = 5'h17;
  localparam logic [7:0] OP_INDBB      = 8'h22;
  localparam logic [7:0] OP_OUTDBB     = 8'h02;
  localparam logic [7:0] OP_CALL_LO    = 8'h14;
  // Register byte addresses.
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STAT   = 8'h04;
  localparam logic [7:0] A_IRQS   = 8'h08;
  localparam logic [7:0] A_MASK   = 8'h0C;
  localparam logic [7:0] A_PMADR  = 8'h10;
  localparam logic [7:0] A_PMDAT  = 8'h14;
  localparam logic [7:0] A_HOSTIN = 8'h18;
  localparam logic [7:0] A_HOSTOUT= 8'h1C;
  localparam logic [7:0] A_PC     = 8'h20;
  localparam logic [7:0] A_ACC    = 8'h24;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SS  = 1;
  localparam int CTRL_STEP= 2;
  localparam int CTRL_TOV = 3;
  localparam int IRQ_W    = 3;
  localparam int IRQ_OBF  = 0;
  localparam int IRQ_IBFC = 1;
  localparam int IRQ_HALT = 2;
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  typedef enum logic [1:0] {
    SMD_FETCH = 2'b00,
    SMD_OPER  = 2'b01,
    SMD_HALT  = 2'b10
  } smd_state_e;
endpackage

//--- testbench/smd_core_tb.sv
// Self-checking bench for the slave controller decoder, driven over AXI4-Lite.
// Assumes the expander model above and program memory that survives a reset.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module smd_core_tb
  import smd_pkg::*;
;
  logic clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic single_step_in, timer_overflow_in, cycle_strobe, expander_strobe, expander_oe, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, expander_in, expander_out, port5;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        i0;
  int          error_cnt = 0, checked = 0, sc = 0, xs = 0;

  smd_core #(.PM_DEPTH(1024)) smd_core_i (.clk(clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .single_step_in(single_step_in),
    .timer_overflow_in(timer_overflow_in), .expander_in(expander_in),
    .cycle_strobe(cycle_strobe), .expander_strobe(expander_strobe),
    .expander_out(expander_out), .expander_oe(expander_oe), .irq(irq));
  smd_expander_model smd_expander_model_i (.clk(clk), .resetn(resetn),
    .expander_strobe(expander_strobe), .expander_out(expander_out),
    .expander_oe(expander_oe), .expander_in(expander_in), .port5(port5));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cycle_strobe === 1'b1) sc++;
    if (expander_strobe === 1'b1) xs++;
  end

  task automatic test_done;
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // The master never assumes a latency; a wait ends on the response or at the 50-cycle limit.
  task automatic axw(input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    `CHK(d, e)
  endtask
  task automatic load(input logic [9:0] a, input logic [7:0] b[$]);
    axw(A_PMADR, {22'h0, a});
    foreach (b[i]) axw(A_PMDAT, {24'h0, b[i]});
  endtask
  task automatic do_reset;
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask
  task automatic step(input int e);
    int c;
    c = sc;
    single_step_in <= 1'b1;
    @(posedge clk);
    single_step_in <= 1'b0;
    repeat (15) @(posedge clk);
    `CHK(sc - c, e)
  endtask

  task automatic t_reset;
    rd_chk(A_PC, 32'h0);
    rd_chk(A_STAT, 32'h0);
    axr(8'h40);
    `CHK(r, RESP_ERR)
    `CHK(d, 32'h0)
    `CHK(irq, 1'b0)
    $display("t_reset done");
  endtask
  task automatic t_irq;
    rd_chk(A_IRQS, 32'h1 << IRQ_IBFC);
    axw(A_MASK, 32'h0);
    repeat (3) @(posedge clk);
    i0 = irq;
    axw(A_MASK, 32'h7);
    repeat (3) @(posedge clk);
    `CHK(i0 ^ irq, 1'b1)
    axw(A_IRQS, 32'h7);
    rd_chk(A_IRQS, 32'h0);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    $display("t_irq done");
  endtask
  task automatic t_flow;
    load(10'h300, '{8'h5A});
    load(10'h0, '{8'hE3, 8'h02, 8'h86, 8'h04, 8'hB8, 8'h03, 8'hE8, 8'h06, 8'h86, 8'h08,
      8'hD6, 8'h0C, 8'hD6, 8'h0C, 8'h22, 8'h52, 8'h13, 8'hD6, 8'h11, 8'h16, 8'h17,
      8'hD6, 8'h15, 8'hD6, 8'h17});
    timer_overflow_in <= 1'b1;
    @(posedge clk);
    timer_overflow_in <= 1'b0;
    axw(A_CTRL, 32'h1);
    repeat (200) @(posedge clk);
    rd_chk(A_STAT, 32'h6);
    rd_chk(A_ACC, 32'h5A);
    rd_chk(A_HOSTOUT, 32'h5A);
    t_irq();
    repeat (50) @(posedge clk);
    axw(A_HOSTIN, 32'h4);
    repeat (200) @(posedge clk);
    axw(A_CTRL, 32'h0);
    repeat (10) @(posedge clk);
    rd_chk(A_PC, 32'h17);
    rd_chk(A_ACC, 32'h4);
    rd_chk(A_STAT, 32'h0);
    $display("t_flow done");
  endtask
  task automatic t_step;
    do_reset();
    rd_chk(A_PC, 32'h0);
    load(10'h300, '{8'h5A});
    load(10'h0, '{8'hD5, 8'hB8, 8'hA7, 8'hE3, 8'h3D, 8'h0C, 8'h8D, 8'h9D, 8'hD6, 8'h08});
    axw(A_CTRL, 32'h3);
    step(1);
    rd_chk(A_STAT, 32'h8);
    step(2);
    step(2);
    axw(A_CTRL, 32'h1);
    repeat (200) @(posedge clk);
    `CHK(xs > 0, 1'b1)
    `CHK(port5, 4'h3)
    rd_chk(A_ACC, 32'h3);
    $display("t_step done");
  endtask

  initial begin
    resetn <= 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
    {single_step_in, timer_overflow_in} <= 2'h0;
    s_axi_awaddr <= 8'h0;
    s_axi_araddr <= 8'h0;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hF;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_flow();
    t_step();
    test_done();
  end
  // The tests need about 1000 cycles, so this limit only trips on a hang.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule // smd_core_tb

//--- testbench/smd_expander_model.sv
// Behavioural model of the four-bit I/O expander on the far side of the strobe pin.
// Assumes two strobe pulses per access: command nibble first, then the data nibble.
`timescale 1ns/1ps
module smd_expander_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       expander_strobe,
  input  wire logic [3:0] expander_out,
  input  wire logic       expander_oe,
  output logic [3:0]      expander_in,
  output logic [3:0]      port5
);
  logic [3:0] ports [4];
  logic [3:0] cmd;
  logic       phase;
  assign port5 = ports[1];
  // Outside a read the lines show the inverse, so a stale sample cannot pass by luck.
  // The command nibble carries the port in its upper pair and the operation in its lower.
  assign expander_in = (phase && cmd[1:0] == 2'h0) ? ports[cmd[3:2]] : ~ports[cmd[3:2]];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 1'b0;
      cmd <= 4'h0;
      ports <= '{4'h3, 4'h0, 4'h0, 4'h0};
    end else if (expander_strobe) begin
      phase <= ~phase;
      if (!phase) begin
        cmd <= expander_out;
      end else if (expander_oe) begin
        case (cmd[1:0])
          2'h1: ports[cmd[3:2]] <= expander_out;
          2'h2: ports[cmd[3:2]] <= ports[cmd[3:2]] | expander_out;
          2'h3: ports[cmd[3:2]] <= ports[cmd[3:2]] & expander_out;
          default: ;
        endcase
      end
    end
  end
endmodule // smd_expander_model
